// ==== inc/whrc_pkg.sv ====
/*
 Package for the watchdog, stop-mode and reset sequencer.
 Holds register offsets, field positions, reset values and timing counts.
*/
`default_nettype none
package whrc_pkg;
   localparam logic [7:0] WHRC_ADDR_PRESCALE = 8'h09;  // watchdog_prescale_select
   localparam logic [7:0] WHRC_ADDR_STATUS   = 8'h0A;  // Flags readable here
   localparam logic [7:0] WHRC_ADDR_CAUSE    = 8'h20;  // Own: wake/reset cause
   localparam int         WHRC_PD_BIT        = 4;
   localparam int         WHRC_TO_BIT        = 5;
   localparam logic [7:0] WHRC_PRESCALE_RST  = 8'h00;
   localparam int         WHRC_FIXED_STAGES  = 8;      // Divide by 256
   localparam int         WHRC_PRESC_STAGES  = 7;      // Up to 1:128
   localparam int         WHRC_INSTR_DIV     = 4;
   localparam int         WHRC_SST_CYCLES    = 1024;
   localparam int         WHRC_SST_W         = 11;
   localparam int         WHRC_SYNC_W        = 8;
   typedef enum logic [1:0] {
      WHRC_ST_RESET,
      WHRC_ST_RUN,
      WHRC_ST_STOP,
      WHRC_ST_DELAY
   } whrc_state_e;
endpackage : whrc_pkg
`default_nettype wire

// ==== inc/whrc_wdt_if.sv ====
/*
 Interface between the sequencer and its watchdog counter.
 Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface whrc_wdt_if;
   logic       tick;      // One-cycle watchdog source tick
   logic       clear;     // Clears divider chain
   logic [2:0] sel;       // Prescale select
   logic       overflow;  // One-cycle overflow pulse
   modport ctrl (output tick, output clear, output sel, input overflow);
   modport cnt  (input tick, input clear, input sel, output overflow);
endinterface : whrc_wdt_if
`default_nettype wire

// ==== hw/whrc_sync.sv ====
/*
 Two-flop synchroniser, one per bit.
 Assumes inputs come from outside i_mclk's domain.
*/
`timescale 1ns/1ps
`default_nettype none
module whrc_sync
   import whrc_pkg::*;
(
   input  wire logic                   i_mclk,
   input  wire logic                   i_rstn,
   input  wire logic [WHRC_SYNC_W-1:0] i_async,
   input  wire logic [WHRC_SYNC_W-1:0] i_rst_val,
   output var  logic [WHRC_SYNC_W-1:0] o_sync
);
   logic [WHRC_SYNC_W-1:0] meta_r;
   logic [WHRC_SYNC_W-1:0] rst_val_unused;

   assign rst_val_unused = i_rst_val;

   // Generate one flop pair per bit; first stage read only by second
   genvar g;
   generate
      for (g = 0; g < WHRC_SYNC_W; g++) begin : g_bit
         always_ff @(posedge i_mclk or negedge i_rstn) begin
            if (!i_rstn) begin
               meta_r[g] <= 1'b1;
               o_sync[g] <= 1'b1;
            end else begin
               meta_r[g] <= i_async[g];
               o_sync[g] <= meta_r[g];
            end
         end
      end
   endgenerate
endmodule : whrc_sync
`default_nettype wire

// ==== hw/whrc_wdt.sv ====
/*
 Watchdog divider chain: fixed 1:256 stage then 1:2^n prescaler.
 Assumes tick is a one-cycle enable already derived from the selected source.
*/
`timescale 1ns/1ps
`default_nettype none
module whrc_wdt
   import whrc_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_rstn,
   whrc_wdt_if.cnt   wdt
);
   localparam int CHAIN_W = WHRC_FIXED_STAGES + WHRC_PRESC_STAGES;
   logic [CHAIN_W:0]   chain_r;
   logic [CHAIN_W:0]   chain_nxt;
   logic [CHAIN_W:0]   chain_inc;
   logic [CHAIN_W-1:0] chain_top;
   logic               ovf_r;
   logic               ovf_hit;
   logic [CHAIN_W:0]   pick_bit;

   // Overflow tap moves up one stage per select step
   assign chain_inc = chain_r + {{CHAIN_W{1'b0}}, 1'b1};
   assign chain_top = {1'b0, {(CHAIN_W-1){1'b1}}};
   assign pick_bit  = ({{CHAIN_W{1'b0}}, 1'b1} << (WHRC_FIXED_STAGES + 32'(wdt.sel)));
   assign ovf_hit   = wdt.tick && ((chain_inc & pick_bit) != '0)
                      && ((chain_r & pick_bit) == '0)
                      && ((chain_r & (pick_bit - 1'b1)) == (pick_bit - 1'b1));  // R3 R4
   assign chain_nxt = (wdt.clear || ovf_hit) ? '0 : (wdt.tick ? chain_inc : chain_r);  // R7
   assign wdt.overflow = ovf_r;

   // Chain restarts after each overflow so the next period is whole
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         chain_r <= '0;
         ovf_r   <= 1'b0;
      end else begin
         chain_r <= chain_nxt;
         ovf_r   <= ovf_hit && !wdt.clear;
      end
   end
   logic unused_top;
   assign unused_top = ^chain_top;
endmodule : whrc_wdt
`default_nettype wire

// ==== hw/whrc_seq.sv ====
/*
 Watchdog, stop-mode and reset sequencer for a small microcontroller core.
 Assumes the core pulses stop and watchdog-clear ops for one cycle, that the
 system oscillator gate and core reset/restart are handled by o_ outputs, and
 that the watchdog RC oscillator is seen here as an asynchronous level.
*/
// Our own choice: the strobed register port.
//Contract
//(R1) Watchdog source: RC oscillator or instruction clock, by configuration option.
//(R2) Watchdog disabled by option makes clear and timeout do nothing.
//(R3) Fixed divide-by-256 chain precedes the prescaler.
//(R4) Three-bit prescale field bits 2:0 gives 1:1 up to 1:128.
//(R5) Overflow while running gives full chip reset and sets timeout flag.
//(R6) Overflow in stop gives warm reset: PC and stack pointer only.
//(R7) Watchdog chain cleared by reset pin, watchdog-clear or stop.
//(R8) Stop switches off system oscillator; RC watchdog source keeps running.
//(R9) Stop retains RAM, registers and port states.
//(R10) Stop sets power-down flag and clears timeout flag.
//(R11) Power-down cleared by power-up or watchdog-clear; timeout set on timeout.
//(R12) Stop exits on pin reset, interrupt, port A edge, watchdog overflow.
//(R13) Per-bit port A wake enable; port wake resumes at next instruction.
//(R14) Interrupt wake vectors only if enabled and stack not full.
//(R15) Wake waits 1024 clocks; interrupt acknowledge adds one more cycle.
//(R16) Interrupt flagged before stop entry does not wake.
//(R17) Flags encode reset cause per the cause table.
//(R18) Start-up delay after power-up and wakes, not after pin reset.
//(R19) Chip reset: PC zero, interrupts off, ports input, watchdog counting.
//(R20) RC mode drives system clock divided by four on oscillator output.
//(R21) Power-down is status bit 4, timeout bit 5, both readable.
//(R22) Warm reset restarts at address zero after wake delay.
//(R23) Reset pin is synchronised before clearing chain and driving reset.
`timescale 1ns/1ps
`default_nettype none
module whrc_seq
   import whrc_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rstn,
   // Configuration options
   input  wire logic       i_opt_wdt_en,
   input  wire logic       i_opt_wdt_rc,
   input  wire logic       i_opt_rc_osc,
   input  wire logic [7:0] i_opt_pa_wake,
   // Pins
   input  wire logic       i_ext_rst_pin_n,
   input  wire logic       i_wdt_rc_clk,
   input  wire logic [7:0] i_port_a,
   output logic            o_osc_out_pin,
   // Core side
   input  wire logic       i_stop_op,
   input  wire logic       i_watchdog_clear_op,
   input  wire logic       i_irq_pend,
   input  wire logic       i_irq_en,
   input  wire logic       i_stack_full,
   output logic            o_sys_osc_en,
   output logic            o_core_hold,
   output logic            o_chip_rst,
   output logic            o_warm_rst,
   output logic            o_irq_vector,
   output logic            o_port_freeze,
   // Register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata
);
   whrc_wdt_if wdt_bus ();

   whrc_state_e          state_r;
   whrc_state_e          state_nxt;
   logic [2:0]           presc_r;
   logic                 to_flag_r;
   logic                 pd_flag_r;
   logic [WHRC_SST_W-1:0] sst_r;
   logic [1:0]           div4_r;
   logic                 osc_out_r;
   logic                 prev_rc_r;
   logic [7:0]           pa_prev_r;
   logic                 irq_mask_r;
   logic                 wake_irq_r;
   logic                 warm_r;
   logic                 ack_extra_r;
   logic                 pin_rst_r;
   logic                 chip_rst_r;
   logic                 warm_rst_r;
   logic                 vec_r;
   logic [7:0]           rdata_r;
   logic [2:0]           cause_r;
   logic [WHRC_SYNC_W-1:0] sync_out;
   logic                 pin_rst_n_s;
   logic                 rc_s;
   logic [5:0]           pa_s;

   // Pin reset, RC clock and port A bits 5:0 come from outside: resynchronise
   whrc_sync u_sync (
      .i_mclk    (i_mclk),
      .i_rstn    (i_rstn),
      .i_async   ({i_port_a[5:0], i_wdt_rc_clk, i_ext_rst_pin_n}),
      .i_rst_val ({WHRC_SYNC_W{1'b1}}),
      .o_sync    (sync_out)
   );
   assign pin_rst_n_s = sync_out[0];  // R23
   assign rc_s        = sync_out[1];
   assign pa_s        = sync_out[7:2];

   whrc_wdt u_wdt (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .wdt    (wdt_bus.cnt)
   );

   // Decode of state and events
   wire        in_stop   = (state_r == WHRC_ST_STOP);
   wire        pin_rst   = !pin_rst_n_s;
   wire        rc_tick   = rc_s && !prev_rc_r;
   wire        instr_tk  = (div4_r == 2'(WHRC_INSTR_DIV - 1));
   // Instruction clock dies in stop; only the RC source ticks there
   wire        src_tick  = i_opt_wdt_rc ? rc_tick : (instr_tk && !in_stop);  // R1 R8
   wire        clr_op    = i_watchdog_clear_op && state_r == WHRC_ST_RUN;
   wire        stop_op   = i_stop_op && state_r == WHRC_ST_RUN;
   wire        wdt_ovf   = wdt_bus.overflow && i_opt_wdt_en;  // R2
   wire [5:0]  pa_fall   = pa_prev_r[5:0] & ~pa_s & i_opt_pa_wake[5:0];  // R13
   wire        pa_wake   = in_stop && (pa_fall != 6'h00);  // R12
   wire        irq_wake  = in_stop && i_irq_pend && !irq_mask_r;  // R16
   wire        irq_go    = irq_wake && i_irq_en && !i_stack_full;  // R14
   wire        sst_done  = (sst_r == '0);
   wire        wr_presc  = i_wr && (i_addr == WHRC_ADDR_PRESCALE);
   wire [7:0]  status_rd = (8'(to_flag_r) << WHRC_TO_BIT) | (8'(pd_flag_r) << WHRC_PD_BIT);  // R21
   wire [7:0]  rd_mux    = (i_addr == WHRC_ADDR_PRESCALE) ? {5'h00, presc_r} :
                           (i_addr == WHRC_ADDR_STATUS)   ? status_rd :
                           (i_addr == WHRC_ADDR_CAUSE)    ? {5'h00, cause_r} : 8'h00;

   assign wdt_bus.tick  = src_tick && i_opt_wdt_en;  // R2
   assign wdt_bus.sel   = presc_r;  // R4
   assign wdt_bus.clear = pin_rst || (i_opt_wdt_en && clr_op) || stop_op;  // R7

   // Next state of the sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         WHRC_ST_RESET: if (sst_done) state_nxt = WHRC_ST_RUN;  // R18
         WHRC_ST_RUN: begin
            if (wdt_ovf) state_nxt = WHRC_ST_RUN;  // R5
            else if (stop_op) state_nxt = WHRC_ST_STOP;
         end
         WHRC_ST_STOP: if (wdt_ovf || pa_wake || irq_wake) state_nxt = WHRC_ST_DELAY;  // R12
         WHRC_ST_DELAY: if (sst_done && !ack_extra_r) state_nxt = WHRC_ST_RUN;  // R15
         default: state_nxt = WHRC_ST_RESET;
      endcase
      if (pin_rst) state_nxt = WHRC_ST_RUN;  // R18
   end

   // Sequencer, start-up timer and wake bookkeeping
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r     <= WHRC_ST_RESET;
         sst_r       <= WHRC_SST_W'(WHRC_SST_CYCLES - 1);  // R18
         irq_mask_r  <= 1'b0;
         wake_irq_r  <= 1'b0;
         warm_r      <= 1'b0;
         ack_extra_r <= 1'b0;
         pin_rst_r   <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         pin_rst_r <= pin_rst;
         if (state_r == WHRC_ST_STOP && state_nxt == WHRC_ST_DELAY) begin
            sst_r       <= WHRC_SST_W'(WHRC_SST_CYCLES - 1);  // R15
            warm_r      <= wdt_ovf;  // R6
            wake_irq_r  <= irq_go && !wdt_ovf;
            ack_extra_r <= irq_go && !wdt_ovf;  // R15
         end else if (!sst_done) begin
            sst_r <= sst_r - 1'b1;
         end else if (state_r == WHRC_ST_DELAY) begin
            ack_extra_r <= 1'b0;
         end
         if (stop_op) irq_mask_r <= i_irq_pend;  // R16
         if (state_nxt == WHRC_ST_RUN) begin
            warm_r     <= 1'b0;
            wake_irq_r <= 1'b0;
         end
      end
   end

   // Status flags: set by event wins over any clear in the same cycle
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         to_flag_r <= 1'b0;  // R11
         pd_flag_r <= 1'b0;  // R11
         cause_r   <= 3'h0;
      end else begin
         if (wdt_ovf) begin
            to_flag_r <= 1'b1;  // R5 R11 R17
            if (in_stop) pd_flag_r <= 1'b1;  // R17
            cause_r   <= in_stop ? 3'h4 : 3'h3;
         end else if (stop_op) begin
            to_flag_r <= 1'b0;  // R10
            pd_flag_r <= 1'b1;  // R10
         end else if (i_opt_wdt_en && clr_op) begin
            to_flag_r <= 1'b0;  // R11
            pd_flag_r <= 1'b0;  // R11
         end else if (pin_rst && in_stop) begin
            to_flag_r <= 1'b0;  // R17
            pd_flag_r <= 1'b1;
            cause_r   <= 3'h2;
         end else if (pin_rst && !pin_rst_r) begin
            cause_r   <= 3'h1;  // R17
         end
      end
   end

   // Prescale register and read port, data one cycle after strobe
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         presc_r <= WHRC_PRESCALE_RST[2:0];
         rdata_r <= 8'h00;
      end else begin
         if (wr_presc) presc_r <= i_wdata[2:0];  // R4
         rdata_r <= i_rd ? rd_mux : 8'h00;
      end
   end

   // Instruction divider and oscillator output; stops with the oscillator
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         div4_r    <= 2'h0;
         osc_out_r <= 1'b0;
         prev_rc_r <= 1'b1;  // Matches synchroniser reset: no false tick
         pa_prev_r <= 8'hFF;
      end else begin
         if (!in_stop) div4_r <= div4_r + 2'h1;
         osc_out_r <= i_opt_rc_osc && div4_r[1];  // R20
         prev_rc_r <= rc_s;
         pa_prev_r <= {2'h3, pa_s};
      end
   end

   // Core-facing controls, all registered
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         chip_rst_r <= 1'b1;  // R19
         warm_rst_r <= 1'b0;
         vec_r      <= 1'b0;
      end else begin
         chip_rst_r <= pin_rst || (wdt_ovf && !in_stop) || state_nxt == WHRC_ST_RESET;  // R5 R19
         warm_rst_r <= (wdt_ovf && in_stop) || (warm_r && state_nxt == WHRC_ST_RUN);  // R6 R22
         vec_r      <= wake_irq_r && state_nxt == WHRC_ST_RUN;  // R14
      end
   end

   assign o_osc_out_pin = osc_out_r;
   assign o_chip_rst    = chip_rst_r;
   assign o_warm_rst    = warm_rst_r;
   assign o_irq_vector  = vec_r;
   assign o_rdata       = rdata_r;

   // Oscillator gate, core hold and port freeze follow state register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sys_osc_en  <= 1'b1;
         o_core_hold   <= 1'b1;
         o_port_freeze <= 1'b0;
      end else begin
         o_sys_osc_en  <= state_nxt != WHRC_ST_STOP;  // R8
         o_core_hold   <= state_nxt != WHRC_ST_RUN;  // R9 R15
         o_port_freeze <= state_nxt == WHRC_ST_STOP || state_nxt == WHRC_ST_DELAY;  // R9
      end
   end
endmodule : whrc_seq
`default_nettype wire

// ==== dv/whrc_seq_props.sv ====
/*
 Checker for whrc_seq: stop entry, wake delay, status reads, reset pin.
 Assumes the single i_mclk domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module whrc_seq_props
   import whrc_pkg::*;
(
   input wire logic       i_mclk,
   input wire logic       i_rstn,
   input wire logic       i_opt_wdt_en,
   input wire logic       i_ext_rst_pin_n,
   input wire logic       i_stop_op,
   input wire logic       i_rd,
   input wire logic [7:0] i_addr,
   input wire logic       o_sys_osc_en,
   input wire logic       o_core_hold,
   input wire logic       o_chip_rst,
   input wire logic       o_warm_rst,
   input wire logic       o_irq_vector,
   input wire logic       o_port_freeze,
   input wire logic [7:0] o_rdata
);
   logic [11:0] dly_cnt_r;
   logic [11:0] dly_cnt_nxt;
   logic        pin_seen_r;
   logic        pin_seen_nxt;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // Wake cycles; a pin reset cuts the delay short, so it is noted apart
   assign dly_cnt_nxt  = (o_port_freeze && o_sys_osc_en) ? dly_cnt_r + 12'h001 : 12'h000;
   assign pin_seen_nxt = o_port_freeze && (pin_seen_r || !i_ext_rst_pin_n);
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         dly_cnt_r  <= 12'h000;
         pin_seen_r <= 1'b0;
      end else begin
         dly_cnt_r  <= dly_cnt_nxt;
         pin_seen_r <= pin_seen_nxt;
      end
   end
   a_rd_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_status_fields: assert property (i_rd && i_addr == WHRC_ADDR_STATUS |=>
      o_rdata[7:6] == 2'b00 && o_rdata[3:0] == 4'h0) else $error("status spare bits set");
   a_stop_osc_off: assert property (i_stop_op && !o_core_hold && i_ext_rst_pin_n |=>
      !o_sys_osc_en) else $error("oscillator still on after stop");
   a_stop_hold_all: assert property (!o_sys_osc_en |-> o_core_hold && o_port_freeze)
      else $error("core or ports not held in stop");
   a_stop_flags: assert property (i_stop_op && !o_core_hold ##2 i_rd &&
      i_addr == WHRC_ADDR_STATUS |=> o_rdata == 8'h10) else $error("flags wrong after stop");
   a_wake_delay: assert property ($fell(o_port_freeze) && !pin_seen_r |->
      dly_cnt_r >= 12'h3fc && dly_cnt_r <= 12'h404) else $error("wake delay length wrong");
   a_pin_rst_sync: assert property (!i_ext_rst_pin_n [*5] |-> o_chip_rst)
      else $error("reset pin not seen as chip reset");
   a_wdt_off_quiet: assert property (!i_opt_wdt_en |-> !o_warm_rst)
      else $error("warm reset with watchdog disabled");
   a_irq_vec_pulse: assert property (o_irq_vector |=> !o_irq_vector && !o_port_freeze)
      else $error("vector pulse too long or ports held");
endmodule : whrc_seq_props
bind whrc_seq whrc_seq_props u_props (.i_mclk, .i_rstn, .i_opt_wdt_en, .i_ext_rst_pin_n,
   .i_stop_op, .i_rd, .i_addr, .o_sys_osc_en, .o_core_hold, .o_chip_rst, .o_warm_rst,
   .o_irq_vector, .o_port_freeze, .o_rdata);
`default_nettype wire

// ==== dv/whrc_far_model.sv ====
/*
 Far-side model: reset pin, watchdog RC clock and port A pins.
 Assumes pins idle high through pull-ups and are driven asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module whrc_far_model (
   output logic       o_rst_pin_n,
   output logic       o_rc_clk,
   output logic [7:0] o_port
);
   // Pull-ups hold pins high; RC oscillator runs free, also in stop
   initial begin
      o_rst_pin_n = 1'b1;
      o_port      = 8'hff;
      o_rc_clk    = 1'b0;
      #3;
      forever #20 o_rc_clk = ~o_rc_clk;
   end
   // Reset pin low for a span, then back to the pull-up level
   task automatic pin_low(input int span);
      o_rst_pin_n = 1'b0;
      #(span);
      o_rst_pin_n = 1'b1;
   endtask : pin_low
   // One falling edge on a port pin, released after 200 ns
   task automatic port_fall(input int b);
      o_port[b] = 1'b0;
      #200;
      o_port[b] = 1'b1;
   endtask : port_fall
endmodule : whrc_far_model
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
 Testbench for whrc_seq: register port, watchdog timeouts, stop and wakes.
 Assumes the far-side model drives the pins and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import whrc_pkg::*;
   logic       i_mclk = 1'b0;
   logic       i_rstn, i_opt_wdt_en, i_opt_wdt_rc, i_opt_rc_osc, i_ext_rst_pin_n, i_wdt_rc_clk;
   logic       i_stop_op, i_watchdog_clear_op, i_irq_pend, i_irq_en, i_stack_full, i_wr, i_rd;
   logic       o_osc_out_pin, o_sys_osc_en, o_core_hold, o_chip_rst, o_warm_rst;
   logic       o_irq_vector, o_port_freeze, vec_seen;
   logic [7:0] i_opt_pa_wake, i_port_a, i_addr, i_wdata, o_rdata, d;
   int         bad_count, n_compared, n, e, k, s;

   whrc_seq dut (.i_mclk, .i_rstn, .i_opt_wdt_en, .i_opt_wdt_rc, .i_opt_rc_osc, .i_opt_pa_wake,
      .i_ext_rst_pin_n, .i_wdt_rc_clk, .i_port_a, .o_osc_out_pin, .i_stop_op,
      .i_watchdog_clear_op, .i_irq_pend, .i_irq_en, .i_stack_full, .o_sys_osc_en,
      .o_core_hold, .o_chip_rst, .o_warm_rst, .o_irq_vector, .o_port_freeze, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata);
   whrc_far_model u_far (.o_rst_pin_n(i_ext_rst_pin_n), .o_rc_clk(i_wdt_rc_clk),
      .o_port(i_port_a));

   // 100 MHz clock and a sticky record of vector pulses
   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      if (o_irq_vector === 1'b1) begin
         vec_seen <= 1'b1;
      end
   end

   task automatic report_and_stop();
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Waits are cycle counts, so windows absorb pin synchroniser slack
   task automatic chk_in(input int lo, input int hi);
      chk(16'(n >= lo && n <= hi), 16'h0001);
   endtask : chk_in
   function automatic int exp_to(input int sel);
      return 1024 << sel;
   endfunction : exp_to
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_addr  <= a;
      i_wdata <= v;
      i_wr    <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd_reg
   task automatic op(input logic stop);
      @(posedge i_mclk);
      i_stop_op           <= stop;
      i_watchdog_clear_op <= !stop;
      @(posedge i_mclk);
      i_stop_op           <= 1'b0;
      i_watchdog_clear_op <= 1'b0;
   endtask : op
   // Sel 0: run, 1: chip reset, 2: warm reset; n holds cycles waited
   task automatic wait_on(input int sel, input int lim);
      for (n = 0; n < lim; n++) begin
         @(posedge i_mclk);
         #1;
         if ((sel == 0 && o_core_hold === 1'b0) || (sel == 1 && o_chip_rst === 1'b1) ||
             (sel == 2 && o_warm_rst === 1'b1)) break;
      end
   endtask : wait_on
   task automatic chk_regs(input logic [7:0] st, input logic [7:0] cause);
      rd_reg(WHRC_ADDR_STATUS);
      chk(d, st);
      rd_reg(WHRC_ADDR_CAUSE);
      chk(d, cause);
   endtask : chk_regs

   initial begin
      #400_000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      s = $urandom(76);
      {i_rstn, i_opt_wdt_en, i_opt_wdt_rc, i_opt_rc_osc, i_stop_op, i_watchdog_clear_op} = '0;
      {i_irq_pend, i_irq_en, i_stack_full, i_wr, i_rd, vec_seen} = '0;
      {i_opt_pa_wake, i_addr, i_wdata} = '0;
      repeat (10) @(posedge i_mclk);
      i_rstn <= 1'b1;
      wait_on(0, 1100);
      chk_in(1018, 1032);
      chk_regs(8'h00, 8'h00);
      // Register port: random select, read-only status, unmapped place
      e = $urandom_range(7);
      wr_reg(WHRC_ADDR_PRESCALE, {5'($urandom), 3'(e)});
      rd_reg(WHRC_ADDR_PRESCALE);
      chk(d & 8'h07, 8'(e));
      wr_reg(WHRC_ADDR_STATUS, 8'hff);
      rd_reg(8'h33);
      chk(d, 8'h00);
      chk_regs(8'h00, 8'h00);
      // Disabled watchdog never times out, even with a clear issued
      op(0);
      wait_on(1, 1100);
      chk(16'(n), 16'h044c);
      // Running timeouts from the instruction clock, then recovery
      for (k = 0; k < 2; k++) begin
         s = k == 0 ? 0 : $urandom_range(1, 2);
         wr_reg(WHRC_ADDR_PRESCALE, 8'(s));
         i_opt_wdt_en <= 1'b1;
         op(0);
         wait_on(1, exp_to(s) + 40);
         chk_in(exp_to(s) - 8, exp_to(s) + 8);
         i_opt_wdt_en <= 1'b0;
         wait_on(0, 1100);
         chk_regs(8'h20, 8'h03);
         i_opt_wdt_en <= 1'b1;
         op(0);
         rd_reg(WHRC_ADDR_STATUS);
         chk(d, 8'h00);
      end
      // Stop, then a port wake on an enabled bit only
      wr_reg(WHRC_ADDR_PRESCALE, 8'h07);
      i_opt_wdt_rc <= 1'b1;
      k = $urandom_range(5);
      i_opt_pa_wake <= 8'h01 << k;
      op(0);
      op(1);
      rd_reg(WHRC_ADDR_STATUS);
      chk(d, 8'h10);
      u_far.port_fall(k == 5 ? 0 : k + 1);
      wait_on(0, 30);
      chk(o_sys_osc_en, 1'b0);
      u_far.port_fall(k);
      wait_on(0, 1100);
      chk_in(990, 1030);
      // Interrupt wakes: vectored, stack full, disabled
      for (k = 0; k < 3; k++) begin
         i_irq_en     <= k != 2;
         i_stack_full <= k == 1;
         vec_seen     <= 1'b0;
         op(1);
         repeat (3) @(posedge i_mclk);
         i_irq_pend <= 1'b1;
         wait_on(0, 1100);
         i_irq_pend <= 1'b0;
         repeat (2) @(posedge i_mclk);
         #1;
         chk(vec_seen, k == 0);
         chk(16'(n), 16'(WHRC_SST_CYCLES + (k == 0 ? 1 : 0)));
      end
      // Pending request at entry does not wake; pin reset leaves stop at once
      i_irq_pend <= 1'b1;
      op(1);
      wait_on(0, 50);
      chk(o_sys_osc_en, 1'b0);
      u_far.pin_low(100);
      wait_on(0, 40);
      chk_in(0, 30);
      i_irq_pend <= 1'b0;
      chk_regs(8'h10, 8'h02);
      // Watchdog overflow in stop gives warm reset, then a running pin reset
      wr_reg(WHRC_ADDR_PRESCALE, 8'h01);
      op(1);
      wait_on(2, 2200);
      chk_in(exp_to(1) - 12, exp_to(1) + 12);
      wait_on(0, 1100);
      chk_in(1016, 1032);
      chk_regs(8'h30, 8'h04);
      wr_reg(WHRC_ADDR_PRESCALE, 8'h07);
      u_far.pin_low(100);
      wait_on(0, 40);
      chk_regs(8'h30, 8'h01);
      // RC mode clock output: half of every four cycles high
      i_opt_rc_osc <= 1'b1;
      repeat (4) @(posedge i_mclk);
      e = 0;
      repeat (40) begin
         @(posedge i_mclk);
         #1;
         e += int'(o_osc_out_pin === 1'b1);
      end
      chk(16'(e), 16'h0014);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
